// ---- verilog/mars_pkg.sv ----
/*
 shared definitions of the sixteen-line serial multiplexer: register indices,
 field layouts, reset values, state codes, rate table and state carriers.
 assumes one 100 MHz clock and a synchronous active-high reset.
*/
// Operation
// - receive 5 to 8 bits, start, stop, parity
// - send 5-8 bits, one/1.5/two stop units
// - frame format per line, shared by rx/tx
// - per-line rates, tx independent of rx
// - 16 lines each way, mark is low
// - steady space never assembles repeated nulls
// - receiver holds one finished character aside
// - receiver samples at sixteen times bit rate
// - recheck start after 8 ticks, mark aborts
// - sample every 16 ticks, count from length
// - parity check sets a parity error flag
// - parameter write goes to selected line
// - shared silo of 64 sixteen-bit entries
// - entries settle low, bottom is next character
// - reading bottom entry shifts the rest down
// - status high byte shows silo fill count
// - status low byte holds alarm threshold
// - fill above threshold and enable raises flag
// - store into full silo sets overflow flag
// - tx sends lsb first, parity before stop
package mars_pkg;

	localparam int unsigned MARS_CLK_HZ = 100_000_000;
	localparam int          MARS_LINES  = 16;

	// register indices on the register port
	localparam logic [2:0] MARS_IDX_SCR = 3'h0;
	localparam logic [2:0] MARS_IDX_NRC = 3'h1;
	localparam logic [2:0] MARS_IDX_LPR = 3'h2;
	localparam logic [2:0] MARS_IDX_SSR = 3'h3;
	localparam logic [2:0] MARS_IDX_TXD = 3'h4;
	localparam logic [2:0] MARS_IDX_TXR = 3'h5;

	// system control register bit positions
	localparam int MARS_SCR_SEL_LSB = 0;
	localparam int MARS_SCR_RXIE    = 6;
	localparam int MARS_SCR_RXINT   = 7;
	localparam int MARS_SCR_OVIE    = 12;
	localparam int MARS_SCR_OVF     = 14;

	// silo and counting constants
	localparam logic [6:0] MARS_SILO_DEPTH = 7'h40;
	localparam logic [7:0] MARS_ALARM_RST  = 8'h00;
	localparam logic [3:0] MARS_TICK_MID   = 4'h7;
	localparam logic [3:0] MARS_TICK_LAST  = 4'hf;
	localparam logic [5:0] MARS_STOP1      = 6'h0f;
	localparam logic [5:0] MARS_STOP15     = 6'h17;
	localparam logic [5:0] MARS_STOP2      = 6'h1f;
	localparam logic [5:0] MARS_BIT_TICKS  = 6'h0f;

	// bit rates in tenths of a baud, code 0 switches the line off
	localparam int unsigned MARS_BAUD_X10 [16] = '{0, 500, 750, 1100, 1345, 1500, 2000, 3000,
		6000, 12000, 18000, 24000, 48000, 96000, 192000, 384000};

	// clocks per sixteenth of a bit for a rate code
	function automatic logic [16:0] mars_div(input int unsigned clk_hz, input int unsigned code);
		int unsigned b;
		b = MARS_BAUD_X10[code];
		if (b == 0) begin
			return 17'h0;
		end
		return 17'((clk_hz / 16 * 10) / b);
	endfunction

	// mask of the data bits for a length code
	function automatic logic [7:0] mars_mask(input logic [1:0] len);
		return 8'hff >> (2'h3 - len);
	endfunction

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [3:0] tx_spd;
		logic [3:0] rx_spd;
		logic       even;
		logic       pen;
		logic       rsvd_lo;
		logic       stop2;
		logic [1:0] len;
	} mars_lp_t;

	typedef struct packed {
		logic       valid;
		logic       ovr;
		logic       frm;
		logic       par;
		logic [3:0] line;
		logic [7:0] data;
	} mars_ent_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} mars_rxs_t;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_PAR   = 5'b01000,
		TX_STOP  = 5'b10000
	} mars_txs_t;

	typedef struct packed {
		mars_rxs_t  st;
		logic [3:0] tick;
		logic [3:0] bits;
		logic [7:0] sh;
		logic       pb;
		logic       prev;
		logic       hv;
		logic [7:0] hd;
		logic       hp;
		logic       hf;
		logic       ho;
	} mars_rx_t;

	typedef struct packed {
		mars_txs_t  st;
		logic [5:0] cnt;
		logic [3:0] bits;
		logic [7:0] sh;
		logic       pv;
		logic       hv;
		logic [7:0] hd;
		logic       mark;
	} mars_tx_t;

	typedef struct packed {
		logic [15:0]             sync1;
		logic [15:0]             sync2;
		mars_lp_t  [15:0]        ctl;
		mars_rx_t  [15:0]        rx;
		mars_tx_t  [15:0]        tx;
		mars_ent_t [63:0]        silo;
		logic [6:0]              count;
		logic [7:0]              alarm;
		logic [3:0]              sel;
		logic                    rxie;
		logic                    rxint;
		logic                    ovie;
		logic                    ovf;
		logic [3:0]              scan;
		logic [15:0]             rdata;
	} mars_st_t;

	typedef struct packed {
		logic [16:0] cnt;
		logic        tick;
	} mars_baud_t;

endpackage

// ---- verilog/mars_baud.sv ----
/*
 sixteen-times bit-rate tick generator for one direction of one line.
 assumes the divisor comes from registered line settings on the same clock.
*/
`timescale 1ns/1ps
module mars_baud
	import mars_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [16:0] div,
	output wire logic        tick
);

	mars_baud_t s_reg;
	mars_baud_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (rst || div == 17'h0) begin
			s_next.cnt = 17'h0;
		end else if (s_reg.cnt >= div - 17'h1) begin
			s_next.cnt  = 17'h0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + 17'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		s_reg <= s_next;
	end

	assign tick = s_reg.tick;

endmodule

// ---- verilog/mars_top.sv ----
/*
 sixteen-line asynchronous multiplexer core: per-line receivers and
 transmitters, per-line parameter holding registers, shared receive silo
 and the register port.
 assumes line inputs are asynchronous pins and the register port is
 driven from logic on ref_clk.
*/
`timescale 1ns/1ps
module mars_top
	import mars_pkg::*;
#(
	parameter int unsigned CLK_HZ = MARS_CLK_HZ
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [2:0]  reg_sel,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output wire logic [15:0] reg_rdata,
	input  wire logic [15:0] ser_in_n,
	output wire logic [15:0] ser_out_n,
	output wire logic        rx_irq,
	output wire logic        ovf_irq
);

	mars_st_t    s_reg;
	mars_st_t    s_next;
	logic [16:0] div_tab [16];
	logic [15:0] rx_tick;
	logic [15:0] tx_tick;

	////////////////////////////////////////////////////////////////////////////
	// rate table and per-line tick generators

	for (genvar k = 0; k < 16; k++) begin : g_tab
		assign div_tab[k] = mars_div(CLK_HZ, k);
	end

	for (genvar i = 0; i < MARS_LINES; i++) begin : g_line
		mars_baud u_rx_baud (
			.ref_clk (ref_clk),
			.rst     (rst),
			.div     (div_tab[s_reg.ctl[i].rx_spd]),
			.tick    (rx_tick[i])
		);
		mars_baud u_tx_baud (
			.ref_clk (ref_clk),
			.rst     (rst),
			.div     (div_tab[s_reg.ctl[i].tx_spd]),
			.tick    (tx_tick[i])
		);
		assign ser_out_n[i] = ~s_reg.tx[i].mark;
	end

	////////////////////////////////////////////////////////////////////////////
	// transmitter start: loads the holding byte and begins the start space

	function automatic mars_tx_t tx_load(input mars_tx_t t, input mars_lp_t lp);
		mars_tx_t r;
		r      = t;
		r.st   = TX_START;
		r.cnt  = MARS_BIT_TICKS;
		r.sh   = t.hd & mars_mask(lp.len);
		r.pv   = (^(t.hd & mars_mask(lp.len))) ^ ~lp.even;
		r.hv   = 1'b0;
		r.mark = 1'b0;
		return r;
	endfunction

	// end of data or parity: enter the stop units
	function automatic mars_tx_t tx_stop(input mars_tx_t t, input mars_lp_t lp);
		mars_tx_t r;
		r      = t;
		r.st   = TX_STOP;
		r.mark = 1'b1;
		if (!lp.stop2) begin
			r.cnt = MARS_STOP1;
		end else if (lp.len == 2'h0) begin
			r.cnt = MARS_STOP15;
		end else begin
			r.cnt = MARS_STOP2;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic        pop;
		logic        mark;
		logic [3:0]  nb;
		logic [3:0]  tot;
		logic [15:0] rd;
		mars_ent_t   ent;
		pop    = 1'b0;
		mark   = 1'b0;
		nb     = 4'h0;
		tot    = 4'h0;
		rd     = 16'h0;
		ent    = '0;
		s_next = s_reg;

		// two-flop synchroniser on the line inputs
		s_next.sync1 = ser_in_n;
		s_next.sync2 = s_reg.sync1;

		// register writes
		if (reg_wr) begin
			case (reg_sel)
				MARS_IDX_SCR: begin
					s_next.sel  = reg_wdata[MARS_SCR_SEL_LSB +: 4];
					s_next.rxie = reg_wdata[MARS_SCR_RXIE];
					s_next.ovie = reg_wdata[MARS_SCR_OVIE];
					if (!reg_wdata[MARS_SCR_OVF]) begin
						s_next.ovf = 1'b0;
					end
				end
				MARS_IDX_LPR: begin
					s_next.ctl[s_reg.sel] = mars_lp_t'(reg_wdata);
				end
				MARS_IDX_SSR: begin
					s_next.alarm = reg_wdata[7:0];
				end
				MARS_IDX_TXD: begin
					if (!s_reg.tx[s_reg.sel].hv) begin
						s_next.tx[s_reg.sel].hd = reg_wdata[7:0];
						s_next.tx[s_reg.sel].hv = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// register reads, data shown the cycle after the strobe
		case (reg_sel)
			MARS_IDX_SCR: begin
				rd[MARS_SCR_SEL_LSB +: 4] = s_reg.sel;
				rd[MARS_SCR_RXIE]         = s_reg.rxie;
				rd[MARS_SCR_RXINT]        = s_reg.rxint;
				rd[MARS_SCR_OVIE]         = s_reg.ovie;
				rd[MARS_SCR_OVF]          = s_reg.ovf;
			end
			MARS_IDX_NRC: begin
				rd = s_reg.silo[0];
			end
			MARS_IDX_SSR: begin
				rd = {1'b0, s_reg.count, s_reg.alarm};
			end
			MARS_IDX_TXR: begin
				for (int i = 0; i < MARS_LINES; i++) begin
					rd[i] = ~s_reg.tx[i].hv;
				end
			end
			default: begin
				rd = 16'h0;
			end
		endcase
		if (reg_rd) begin
			s_next.rdata = rd;
		end

		// silo read: bottom leaves, the rest bubble down
		pop = reg_rd && reg_sel == MARS_IDX_NRC && s_reg.count != 7'h0;
		if (pop) begin
			for (int k = 0; k < 63; k++) begin
				s_next.silo[k] = s_reg.silo[k+1];
			end
			s_next.silo[63] = '0;
			s_next.count    = s_reg.count - 7'h1;
		end

		// scanner: one line per cycle moves its held character to the silo
		if (s_reg.rx[s_reg.scan].hv) begin
			if (s_next.count != MARS_SILO_DEPTH) begin
				ent.valid = 1'b1;
				ent.ovr   = s_reg.rx[s_reg.scan].ho;
				ent.frm   = s_reg.rx[s_reg.scan].hf;
				ent.par   = s_reg.rx[s_reg.scan].hp;
				ent.line  = s_reg.scan;
				ent.data  = s_reg.rx[s_reg.scan].hd;
				s_next.silo[s_next.count[5:0]] = ent;
				s_next.count                   = s_next.count + 7'h1;
				s_next.rx[s_reg.scan].hv       = 1'b0;
				s_next.rx[s_reg.scan].ho       = 1'b0;
			end else begin
				s_next.ovf = 1'b1;
			end
		end
		s_next.scan = s_reg.scan + 4'h1;

		// receivers
		for (int i = 0; i < MARS_LINES; i++) begin
			mark = ~s_reg.sync2[i];
			nb   = {2'b00, s_reg.ctl[i].len} + 4'h5;
			tot  = nb + {3'b000, s_reg.ctl[i].pen};
			if (rx_tick[i]) begin
				unique case (s_reg.rx[i].st)
					RX_IDLE: begin
						s_next.rx[i].prev = mark;
						if (s_reg.rx[i].prev && !mark) begin
							s_next.rx[i].st   = RX_START;
							s_next.rx[i].tick = 4'h0;
						end
					end
					RX_START: begin
						if (s_reg.rx[i].tick == MARS_TICK_MID) begin
							if (mark) begin
								s_next.rx[i].st   = RX_IDLE;
								s_next.rx[i].prev = 1'b1;
							end else begin
								s_next.rx[i].st   = RX_DATA;
								s_next.rx[i].tick = 4'h0;
								s_next.rx[i].bits = 4'h0;
								s_next.rx[i].sh   = 8'h00;
								s_next.rx[i].pb   = 1'b0;
							end
						end else begin
							s_next.rx[i].tick = s_reg.rx[i].tick + 4'h1;
						end
					end
					RX_DATA: begin
						s_next.rx[i].tick = s_reg.rx[i].tick + 4'h1;
						if (s_reg.rx[i].tick == MARS_TICK_LAST) begin
							if (s_reg.rx[i].bits < nb) begin
								s_next.rx[i].sh[s_reg.rx[i].bits[2:0]] = mark;
							end else begin
								s_next.rx[i].pb = mark;
							end
							s_next.rx[i].bits = s_reg.rx[i].bits + 4'h1;
							if (s_reg.rx[i].bits == tot - 4'h1) begin
								s_next.rx[i].st = RX_STOP;
							end
						end
					end
					RX_STOP: begin
						s_next.rx[i].tick = s_reg.rx[i].tick + 4'h1;
						if (s_reg.rx[i].tick == MARS_TICK_LAST) begin
							s_next.rx[i].st   = RX_IDLE;
							s_next.rx[i].prev = mark;
							s_next.rx[i].ho   = s_next.rx[i].hv;
							s_next.rx[i].hv   = 1'b1;
							s_next.rx[i].hd   = s_reg.rx[i].sh;
							s_next.rx[i].hf   = ~mark;
							s_next.rx[i].hp   = s_reg.ctl[i].pen
								& ((^s_reg.rx[i].sh) ^ s_reg.rx[i].pb ^ ~s_reg.ctl[i].even);
						end
					end
				endcase
			end
		end

		// transmitters
		for (int i = 0; i < MARS_LINES; i++) begin
			nb = {2'b00, s_reg.ctl[i].len} + 4'h5;
			if (tx_tick[i]) begin
				unique case (s_reg.tx[i].st)
					TX_IDLE: begin
						if (s_reg.tx[i].hv) begin
							s_next.tx[i] = tx_load(s_reg.tx[i], s_reg.ctl[i]);
						end
					end
					TX_START: begin
						s_next.tx[i].cnt = s_reg.tx[i].cnt - 6'h1;
						if (s_reg.tx[i].cnt == 6'h0) begin
							s_next.tx[i].st   = TX_DATA;
							s_next.tx[i].cnt  = MARS_BIT_TICKS;
							s_next.tx[i].bits = 4'h0;
							s_next.tx[i].mark = s_reg.tx[i].sh[0];
						end
					end
					TX_DATA: begin
						s_next.tx[i].cnt = s_reg.tx[i].cnt - 6'h1;
						if (s_reg.tx[i].cnt == 6'h0) begin
							if (s_reg.tx[i].bits != nb - 4'h1) begin
								s_next.tx[i].bits = s_reg.tx[i].bits + 4'h1;
								s_next.tx[i].sh   = s_reg.tx[i].sh >> 1;
								s_next.tx[i].mark = s_reg.tx[i].sh[1];
								s_next.tx[i].cnt  = MARS_BIT_TICKS;
							end else if (s_reg.ctl[i].pen) begin
								s_next.tx[i].st   = TX_PAR;
								s_next.tx[i].mark = s_reg.tx[i].pv;
								s_next.tx[i].cnt  = MARS_BIT_TICKS;
							end else begin
								s_next.tx[i] = tx_stop(s_next.tx[i], s_reg.ctl[i]);
							end
						end
					end
					TX_PAR: begin
						s_next.tx[i].cnt = s_reg.tx[i].cnt - 6'h1;
						if (s_reg.tx[i].cnt == 6'h0) begin
							s_next.tx[i] = tx_stop(s_next.tx[i], s_reg.ctl[i]);
						end
					end
					TX_STOP: begin
						s_next.tx[i].cnt = s_reg.tx[i].cnt - 6'h1;
						if (s_reg.tx[i].cnt == 6'h0) begin
							if (s_reg.tx[i].hv) begin
								s_next.tx[i] = tx_load(s_reg.tx[i], s_reg.ctl[i]);
							end else begin
								s_next.tx[i].st = TX_IDLE;
							end
						end
					end
				endcase
			end
		end

		// receive alarm flag follows fill level against threshold
		s_next.rxint = ({1'b0, s_next.count} > s_next.alarm) && s_next.rxie;

		if (rst) begin
			s_next       = '0;
			s_next.alarm = MARS_ALARM_RST;
			for (int i = 0; i < MARS_LINES; i++) begin
				s_next.rx[i].st   = RX_IDLE;
				s_next.tx[i].st   = TX_IDLE;
				s_next.tx[i].mark = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata = s_reg.rdata;
	assign rx_irq    = s_reg.rxint;
	assign ovf_irq   = s_reg.ovf & s_reg.ovie;

endmodule

// ---- tb/mars_top_sva.sv ----
/*
 checker for the multiplexer core register port and line outputs.
 assumes it is bound to mars_top and sees only its ports.
*/
`timescale 1ns/1ps
module mars_top_chk
	import mars_pkg::*;
#(
	parameter int unsigned CLK_HZ = MARS_CLK_HZ
)(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [2:0]  reg_sel,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] ser_in_n,
	input wire logic [15:0] ser_out_n,
	input wire logic        rx_irq,
	input wire logic        ovf_irq
);
	logic [7:0] alarm_reg;
	logic [7:0] alarm_next;
	logic       rd_nrc;
	logic       rd_ssr;
	logic       wr_scr;
	assign rd_nrc = reg_rd && reg_sel == MARS_IDX_NRC;
	assign rd_ssr = reg_rd && reg_sel == MARS_IDX_SSR;
	assign wr_scr = reg_wr && reg_sel == MARS_IDX_SCR;
	////////////////////////////////////////////////////////////////////////////////
	// mirror of the alarm byte
	always_comb begin
		alarm_next = alarm_reg;
		if (reg_wr && reg_sel == MARS_IDX_SSR) begin
			alarm_next = reg_wdata[7:0];
		end
	end
	always_ff @(posedge ref_clk) begin
		alarm_reg <= rst ? MARS_ALARM_RST : alarm_next;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	AST_RST_IDLE: assert property ($fell(rst) |-> ({ser_out_n, reg_rdata} == 32'h0 && !rx_irq && !ovf_irq))
		else $error("outputs not at reset values");
	AST_IDLE_MARK: assert property ($fell(rst) |-> (ser_out_n == 16'h0) [*8])
		else $error("idle line not mark");
	AST_LPR_WO: assert property (reg_rd && reg_sel == MARS_IDX_LPR |=> reg_rdata == 16'h0)
		else $error("parameter register readable");
	AST_NRC_EMPTY: assert property (rd_nrc |=> (reg_rdata[15] || reg_rdata == 16'h0))
		else $error("empty silo read not zero");
	AST_FILL_MAX: assert property (rd_ssr |=> reg_rdata[15:8] <= 8'h40)
		else $error("fill count above depth");
	AST_ALARM_RW: assert property (rd_ssr |=> reg_rdata[7:0] == $past(alarm_reg))
		else $error("alarm byte mismatch");
	AST_RDATA_STANDS: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	AST_RXIE_OFF: assert property (wr_scr && !reg_wdata[MARS_SCR_RXIE] |-> ##[1:3] !rx_irq)
		else $error("receive flag without enable");
	AST_OVIE_OFF: assert property (wr_scr && !reg_wdata[MARS_SCR_OVIE] |-> ##[1:3] !ovf_irq)
		else $error("overflow flag without enable");
	cover property (rd_nrc ##1 reg_rdata[15]);
	cover property ($rose(rx_irq));
	cover property ($rose(ovf_irq));
endmodule

bind mars_top mars_top_chk #(.CLK_HZ(CLK_HZ)) u_chk (.ref_clk(ref_clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ser_in_n(ser_in_n), .ser_out_n(ser_out_n),
	.rx_irq(rx_irq), .ovf_irq(ovf_irq));

// ---- tb/mars_term.sv ----
/*
 remote terminals on all sixteen lines: send and receive framed characters.
 assumes negative logic lines, idle at mark (low).
*/
`timescale 1ns/1ps
module mars_term #(
	parameter int BIT_CLKS = 160
)(
	input  wire logic [15:0] ser_out_n,
	input  wire logic        ref_clk,
	output logic      [15:0] ser_in_n
);
	initial ser_in_n = 16'h0;
	////////////////////////////////////////////////////////////////////////////////
	task automatic hold(input logic [15:0] m, input logic lvl, input int n);
		@(posedge ref_clk);
		ser_in_n <= lvl ? (ser_in_n | m) : (ser_in_n & ~m);
		repeat (n) @(posedge ref_clk);
	endtask
	// start space, data lsb first, parity, stop marks
	task automatic send(input logic [15:0] m, input logic [7:0] d, input int nb, input logic pen, input logic pb,
		input int stops);
		int i;
		hold(m, 1'b0, BIT_CLKS); // idle mark first, a newly enabled receiver needs mark before start
		hold(m, 1'b1, BIT_CLKS);
		for (i = 0; i < nb; i++) begin
			hold(m, ~d[i], BIT_CLKS);
		end
		if (pen) begin
			hold(m, ~pb, BIT_CLKS);
		end
		hold(m, 1'b0, BIT_CLKS * stops);
	endtask
	task automatic recv(input int line, input int nb, input logic pen, input int bitc, output logic [7:0] d,
		output logic p, output logic ok);
		int i;
		d = 8'h00;
		p = 1'b0;
		ok = 1'b0;
		for (i = 0; i < 8 * bitc && !ok; i++) begin
			@(posedge ref_clk);
			ok = ser_out_n[line];
		end
		repeat (bitc / 2) @(posedge ref_clk);
		ok = ok & ser_out_n[line];
		for (i = 0; i < nb; i++) begin
			repeat (bitc) @(posedge ref_clk);
			d[i] = ~ser_out_n[line];
		end
		if (pen) begin
			repeat (bitc) @(posedge ref_clk);
			p = ~ser_out_n[line];
		end
		repeat (bitc) @(posedge ref_clk);
		ok = ok & ~ser_out_n[line];
	endtask
endmodule

// ---- tb/mars_top_bench.sv ----
/*
 self-checking bench of the multiplexer core with terminals on all lines.
 assumes CLK_HZ scaled so the fastest rate is 160 clocks per bit.
*/
`timescale 1ns/1ps
module mars_top_bench;
	import mars_pkg::*;
	typedef struct packed {
		logic [3:0] line;
		logic [1:0] len;
		logic       stop2;
		logic       pen;
		logic       even;
		logic       bad;
		logic [3:0] tx_sp;
		logic [7:0] d;
	} mars_row_t;
	localparam int BITC = 160;
	logic        ref_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [2:0]  reg_sel   = 3'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [15:0] reg_wdata = 16'h0;
	logic [15:0] scr_en    = 16'h0;
	wire  logic [15:0] reg_rdata;
	wire  logic [15:0] ser_in_n;
	wire  logic [15:0] ser_out_n;
	wire  logic        rx_irq;
	wire  logic        ovf_irq;
	int          err_count = 0;
	int          n_checks  = 0;
	mars_row_t   rows [4]  = '{
		'{4'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf, 8'ha5},
		'{4'h5, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 4'he, 8'h13},
		'{4'h9, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 8'h2c},
		'{4'hf, 2'h2, 1'b1, 1'b1, 1'b1, 1'b0, 4'he, 8'h7f}};
	always #5 ref_clk = ~ref_clk;
	mars_top #(.CLK_HZ(6_144_000)) uut (.ref_clk(ref_clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ser_in_n(ser_in_n),
		.ser_out_n(ser_out_n), .rx_irq(rx_irq), .ovf_irq(ovf_irq));
	mars_term #(.BIT_CLKS(BITC)) term (.ref_clk(ref_clk), .ser_out_n(ser_out_n), .ser_in_n(ser_in_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] s, input logic [15:0] d);
		@(posedge ref_clk);
		reg_sel <= s;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] s, output logic [15:0] d);
		@(posedge ref_clk);
		reg_sel <= s;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic cfg(input logic [3:0] line, input logic [15:0] lpr);
		wr(MARS_IDX_SCR, scr_en | {12'h0, line});
		wr(MARS_IDX_LPR, lpr);
	endtask
	task automatic fill_wait(input logic [7:0] n);
		logic [15:0] g;
		for (int i = 0; i < 200; i++) begin
			rd(MARS_IDX_SSR, g);
			if (g[15:8] === n) return;
		end
		err_count++;
		$display("CHECK FAILED at %0t: silo fill wait ran out", $time);
		test_done();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge ref_clk);
		err_count++;
		$display("CHECK FAILED at %0t: run too long", $time);
		test_done();
	end
	initial begin
		logic [15:0] g;
		logic [15:0] e;
		logic [7:0]  msk;
		logic [7:0]  gd;
		logic        gp;
		logic        ok;
		logic        pb;
		int          nb;
		int          n;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rd(MARS_IDX_SSR, g);
		chk(g, 16'h0000, "status after reset");
		rd(MARS_IDX_NRC, g);
		chk(g, 16'h0000, "empty silo");
		rd(MARS_IDX_LPR, g);
		chk(g, 16'h0000, "write-only params");
		rd(MARS_IDX_TXR, g);
		chk(g, 16'hffff, "tx holdings empty");
		rd(3'h7, g);
		chk(g, 16'h0000, "unmapped");
		wr(MARS_IDX_SSR, 16'hff3f);
		rd(MARS_IDX_SSR, g);
		chk(g, 16'h003f, "alarm write, count read-only");
		$display("test reset done");
		foreach (rows[r]) begin
			nb = 5 + rows[r].len;
			msk = 8'hff >> (2'h3 - rows[r].len);
			pb = rows[r].even ? ^(rows[r].d & msk) : ~^(rows[r].d & msk);
			cfg(rows[r].line, {2'h0, rows[r].tx_sp, 4'hf, rows[r].even, rows[r].pen, 1'b0, rows[r].stop2,
				rows[r].len});
			term.send(16'h1 << rows[r].line, rows[r].d & msk, nb, rows[r].pen, pb ^ rows[r].bad, 1);
			fill_wait(8'h01);
			rd(MARS_IDX_NRC, g);
			e = {3'b100, rows[r].bad & rows[r].pen, rows[r].line, rows[r].d & msk};
			chk(g, e, "rx entry");
			wr(MARS_IDX_TXD, {8'h0, rows[r].d});
			term.recv(rows[r].line, nb, rows[r].pen, (rows[r].tx_sp == 4'hf) ? BITC : 2 * BITC, gd, gp, ok);
			chk({6'h0, ok, gp, gd}, {7'h1, rows[r].pen & pb, rows[r].d & msk}, "tx frame");
		end
		$display("test frames done");
		term.hold(16'h1, 1'b1, BITC / 4);
		term.hold(16'h1, 1'b0, 4 * BITC);
		rd(MARS_IDX_SSR, g);
		chk(g, 16'h003f, "short space ignored");
		term.hold(16'h1, 1'b1, 20 * BITC);
		term.hold(16'h1, 1'b0, 2 * BITC);
		rd(MARS_IDX_SSR, g);
		chk(g, 16'h013f, "one entry for steady space");
		rd(MARS_IDX_NRC, g);
		chk(g, 16'ha000, "framing entry");
		$display("test start detect done");
		scr_en = 16'h1040;
		for (int i = 0; i < 16; i++) begin
			cfg(4'(i), 16'h3fc3);
		end
		for (int k = 0; k < 5; k++) begin
			term.send(16'hffff, 8'h30 + 8'(k), 8, 1'b0, 1'b0, 1);
		end
		fill_wait(8'h40);
		chk({14'h0, rx_irq, ovf_irq}, 16'h0003, "irq at full");
		rd(MARS_IDX_SCR, g);
		chk(g & 16'h50c0, 16'h50c0, "control flags");
		n = 0;
		for (int i = 0; i < 100 && n == i; i++) begin
			rd(MARS_IDX_NRC, g);
			if (g[15] === 1'b1) begin
				n++;
				if (i == 0) chk({8'h0, g[7:0]}, 16'h0030, "oldest first");
				if (i == 79) chk({8'h0, g[7:0]}, 16'h0034, "held chars last");
				if (g[14:12] !== 3'h0) chk({13'h0, g[14:12]}, 16'h0, "no loss");
			end
		end
		chk(16'(n), 16'h0050, "entries drained");
		rd(MARS_IDX_SSR, g);
		chk(g, 16'h003f, "silo empty");
		wr(MARS_IDX_SCR, 16'h1040);
		repeat (4) @(posedge ref_clk);
		chk({14'h0, rx_irq, ovf_irq}, 16'h0000, "flags cleared");
		wr(MARS_IDX_SCR, 16'h0000);
		$display("test silo done");
		test_done();
	end
endmodule
